// File: hdl/supervisor_timer_compare.sv
// Supervisor and guest timer compare registers, pending bits and CSR access checks
`timescale 1ns/1ps
`include "sup_timer_defines.svh"

module supervisor_timer_compare
  import sup_timer_pkg::*;
(
  // Clock and reset
  input  logic        clock,
  input  logic        reset_n,
  input  logic        clock_en,
  // Hart state
  input  logic        xlen32,
  input  logic        hart_virt,
  // CSR access
  input  logic        csr_req,
  input  logic        csr_write,
  input  logic [11:0] csr_addr,
  input  word64_t     csr_wdata,
  input  priv_mode_t  csr_priv,
  input  logic        csr_virt,
  output logic        csr_hit,
  output logic        csr_ack,
  output logic        csr_illegal,
  output logic        csr_virtual_fault,
  output word64_t     csr_rdata,
  // Counter enable and environment config
  input  logic        mcounteren_tm,
  input  logic        hcounteren_tm,
  input  word64_t     env_wdata,
  input  logic        menvcfg_we,
  input  logic        menvcfgh_we,
  input  logic        henvcfg_we,
  input  logic        henvcfgh_we,
  output logic        menvcfg_compare_feature_enable,
  output logic        henvcfg_compare_feature_enable,
  // Pending bits
  input  logic        mip_sup_timer_pending_we,
  input  logic        mip_sup_timer_pending_wdata,
  input  logic        hvip_guest_timer_pending,
  output logic        mip_sup_timer_pending,
  output logic        sip_sup_timer_pending,
  output logic        hip_guest_timer_pending,
  // Interrupt gating
  input  logic        sup_timer_int_enable,
  input  logic        sup_int_allowed,
  input  logic        guest_timer_int_enable,
  input  logic        guest_int_allowed,
  output logic        sup_timer_irq,
  output logic        guest_timer_irq,
  // Time
  input  word64_t     time_value,
  input  word64_t     time_delta
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  word64_t sup_cmp;
  word64_t guest_cmp;
  logic    henvcfg_compare_feature_enable_q;
  logic    legacy_sup_timer_pending;
  word64_t guest_time_sum;
  word64_t cmp_lhs [`CMP_CHANNELS];
  word64_t cmp_rhs [`CMP_CHANNELS];
  logic    [`CMP_CHANNELS-1:0] cmp_ge;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic word64_t merge_write(input word64_t old, input word64_t wdata,
                                          input logic narrow, input logic high);
    if (!narrow) begin
      merge_write = wdata;
    end else if (high) begin
      merge_write = {wdata[31:0], old[31:0]};
    end else begin
      merge_write = {old[63:32], wdata[31:0]};
    end
  endfunction : merge_write

  function automatic word64_t read_view(input word64_t val, input logic narrow,
                                        input logic high);
    if (!narrow) begin
      read_view = val;
    end else if (high) begin
      read_view = {32'h0000_0000, val[63:32]};
    end else begin
      read_view = {32'h0000_0000, val[31:0]};
    end
  endfunction : read_view

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic addr_sup;
  logic addr_guest;
  logic addr_high;
  logic target_guest;
  logic guest_direct;

  assign addr_sup     = (csr_addr == `CSR_SUP_CMP) ||
                        (xlen32 && (csr_addr == `CSR_SUP_CMP_HIGH));
  assign addr_guest   = (csr_addr == `CSR_GUEST_CMP) ||
                        (xlen32 && (csr_addr == `CSR_GUEST_CMP_HIGH));
  assign addr_high    = (csr_addr == `CSR_SUP_CMP_HIGH) ||
                        (csr_addr == `CSR_GUEST_CMP_HIGH);
  assign csr_hit      = addr_sup || addr_guest;
  assign guest_direct = csr_virt && addr_guest;
  // Guest-mode supervisor numbers land on the guest compare
  assign target_guest = addr_guest || (csr_virt && addr_sup);

  // --------------------------------------------------------------------------
  // Access check
  // --------------------------------------------------------------------------
  logic next_illegal;
  logic next_virtual;
  logic access_ok;
  logic wr_en;

  // Illegal outranks virtual: machine-level gates are checked first
  always_comb begin
    next_illegal = 1'h0;
    next_virtual = 1'h0;
    if (csr_priv != priv_machine) begin
      if (!mcounteren_tm || !menvcfg_compare_feature_enable) begin
        next_illegal = 1'h1;
      end else if (csr_priv == priv_user) begin
        next_illegal = !csr_virt;
        next_virtual = csr_virt;
      end else if (csr_virt) begin
        if (guest_direct) begin
          next_virtual = 1'h1;
        end else if (!hcounteren_tm) begin
          next_virtual = 1'h1;
        end else if (!henvcfg_compare_feature_enable) begin
          next_virtual = 1'h1;
        end
      end
    end
  end

  assign access_ok = !next_illegal && !next_virtual;
  assign wr_en     = clock_en && csr_req && csr_write && csr_hit && access_ok;

  // --------------------------------------------------------------------------
  // Compare registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sup_cmp <= `CMP_RESET;
    end else if (wr_en && !target_guest) begin
      sup_cmp <= merge_write(sup_cmp, csr_wdata, xlen32, addr_high);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      guest_cmp <= `CMP_RESET;
    end else if (wr_en && target_guest) begin
      guest_cmp <= merge_write(guest_cmp, csr_wdata, xlen32, addr_high);
    end
  end

  // --------------------------------------------------------------------------
  // CSR answer
  // --------------------------------------------------------------------------
  // Read data is the value before a write in the same access
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      csr_ack           <= 1'h0;
      csr_illegal       <= 1'h0;
      csr_virtual_fault <= 1'h0;
      csr_rdata         <= 64'h0000_0000_0000_0000;
    end else if (clock_en) begin
      csr_ack           <= csr_req && csr_hit;
      csr_illegal       <= csr_req && csr_hit && next_illegal;
      csr_virtual_fault <= csr_req && csr_hit && next_virtual;
      if (csr_req && csr_hit && access_ok) begin
        csr_rdata <= read_view(target_guest ? guest_cmp : sup_cmp, xlen32, addr_high);
      end else begin
        csr_rdata <= 64'h0000_0000_0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Environment config enables
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      menvcfg_compare_feature_enable <= `COMPARE_FEATURE_ENABLE_RESET;
    end else if (clock_en && menvcfg_we) begin
      menvcfg_compare_feature_enable <= env_wdata[`ENVCFG_COMPARE_FEATURE_ENABLE_BIT];
    end else if (clock_en && menvcfgh_we) begin
      menvcfg_compare_feature_enable <= env_wdata[`ENVCFGH_COMPARE_FEATURE_ENABLE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      henvcfg_compare_feature_enable_q <= `COMPARE_FEATURE_ENABLE_RESET;
    end else if (clock_en && henvcfg_we) begin
      henvcfg_compare_feature_enable_q <= env_wdata[`ENVCFG_COMPARE_FEATURE_ENABLE_BIT];
    end else if (clock_en && henvcfgh_we) begin
      henvcfg_compare_feature_enable_q <= env_wdata[`ENVCFGH_COMPARE_FEATURE_ENABLE_BIT];
    end
  end

  // Hypervisor enable is masked, not cleared, so it returns when re-enabled
  assign henvcfg_compare_feature_enable = menvcfg_compare_feature_enable && henvcfg_compare_feature_enable_q;

  // --------------------------------------------------------------------------
  // Comparators
  // --------------------------------------------------------------------------
  // Time is trusted to be synchronous and monotonic, so no synchroniser
  assign guest_time_sum           = time_value + time_delta;
  assign cmp_lhs[`CMP_CH_SUP]     = time_value;
  assign cmp_rhs[`CMP_CH_SUP]     = sup_cmp;
  assign cmp_lhs[`CMP_CH_GUEST]   = guest_time_sum;
  assign cmp_rhs[`CMP_CH_GUEST]   = guest_cmp;

  genvar ch;
  generate
    for (ch = 0; ch < `CMP_CHANNELS; ch = ch + 1) begin : g_cmp
      timer_ge_compare u_cmp (
        .clock         (clock),
        .reset_n       (reset_n),
        .clock_en      (clock_en),
        .count_value   (cmp_lhs[ch]),
        .compare_value (cmp_rhs[ch]),
        .at_or_past    (cmp_ge[ch])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Pending bits
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      legacy_sup_timer_pending <= 1'h0;
    end else if (clock_en && mip_sup_timer_pending_we && !menvcfg_compare_feature_enable) begin
      legacy_sup_timer_pending <= mip_sup_timer_pending_wdata;
    end
  end

  // Compare-driven level: no latch, so it falls only when compare passes time
  assign mip_sup_timer_pending  = menvcfg_compare_feature_enable ? cmp_ge[`CMP_CH_SUP] : legacy_sup_timer_pending;
  assign sip_sup_timer_pending  = mip_sup_timer_pending;
  assign hip_guest_timer_pending = hvip_guest_timer_pending ||
                     (henvcfg_compare_feature_enable && cmp_ge[`CMP_CH_GUEST]);

  // --------------------------------------------------------------------------
  // Interrupt requests
  // --------------------------------------------------------------------------
  assign sup_timer_irq   = mip_sup_timer_pending && sup_timer_int_enable && sup_int_allowed;
  assign guest_timer_irq = hip_guest_timer_pending && guest_timer_int_enable &&
                           guest_int_allowed && hart_virt;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_SUP_PENDING_SET: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_en && menvcfg_compare_feature_enable && (time_value >= sup_cmp)) ##1 menvcfg_compare_feature_enable |-> mip_sup_timer_pending)
    else $error("supervisor pending missing after compare reached");

  AST_SUP_PENDING_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_en && menvcfg_compare_feature_enable && (time_value < sup_cmp)) ##1 menvcfg_compare_feature_enable |-> !mip_sup_timer_pending)
    else $error("supervisor pending held while compare exceeds time");

  AST_GUEST_PENDING_SET: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_en && henvcfg_compare_feature_enable && (guest_time_sum >= guest_cmp)) ##1 henvcfg_compare_feature_enable
      |-> hip_guest_timer_pending)
    else $error("guest pending missing after offset time reached compare");

  AST_GUEST_INJECT: assert property (@(posedge clock) disable iff (!reset_n)
    hvip_guest_timer_pending |-> hip_guest_timer_pending)
    else $error("injected guest pending not visible");

  AST_GUEST_LEGACY: assert property (@(posedge clock) disable iff (!reset_n)
    (menvcfg_compare_feature_enable && !henvcfg_compare_feature_enable_q) |-> (hip_guest_timer_pending == hvip_guest_timer_pending))
    else $error("guest pending not legacy while hypervisor enable clear");

  AST_HENV_MASKED: assert property (@(posedge clock) disable iff (!reset_n)
    !menvcfg_compare_feature_enable |-> !henvcfg_compare_feature_enable)
    else $error("hypervisor enable visible while machine enable clear");

  AST_TM_ILLEGAL: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_en && csr_req && csr_hit && (csr_priv != priv_machine) && !mcounteren_tm)
      |=> (csr_ack && csr_illegal && !csr_virtual_fault))
    else $error("non-machine access with timer access clear not illegal");

  AST_VIRT_FAULT: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_en && csr_req && csr_virt && (csr_priv == priv_supervisor) &&
     (csr_addr == `CSR_SUP_CMP) && mcounteren_tm && menvcfg_compare_feature_enable && !hcounteren_tm)
      |=> (csr_virtual_fault && !csr_illegal))
    else $error("guest access with hypervisor timer access clear not virtual fault");

  AST_LEGACY_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_en && !menvcfg_compare_feature_enable && mip_sup_timer_pending_we) ##1 !menvcfg_compare_feature_enable
      |-> (mip_sup_timer_pending == $past(mip_sup_timer_pending_wdata)))
    else $error("machine write of supervisor pending lost");

  AST_GUEST_REDIRECT: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_en && csr_virt && !xlen32 && (csr_addr == `CSR_SUP_CMP))
      |=> ((guest_cmp == $past(csr_wdata)) && $stable(sup_cmp)))
    else $error("guest write to supervisor number not redirected");

  AST_GUEST_IRQ_VIRT: assert property (@(posedge clock) disable iff (!reset_n)
    guest_timer_irq |-> (hart_virt && hip_guest_timer_pending && guest_timer_int_enable))
    else $error("guest timer interrupt outside virtualized mode");

  AST_SUP_IRQ_GATED: assert property (@(posedge clock) disable iff (!reset_n)
    sup_timer_irq |-> (mip_sup_timer_pending && sup_timer_int_enable && sup_int_allowed))
    else $error("supervisor timer interrupt without enable");

  COV_SUP_FIRE: cover property (@(posedge clock) disable iff (!reset_n)
    menvcfg_compare_feature_enable && $rose(mip_sup_timer_pending));
  COV_GUEST_FIRE: cover property (@(posedge clock) disable iff (!reset_n)
    henvcfg_compare_feature_enable && !hvip_guest_timer_pending && $rose(hip_guest_timer_pending));
  COV_VIRT_FAULT: cover property (@(posedge clock) disable iff (!reset_n)
    csr_virtual_fault);
  COV_ILLEGAL: cover property (@(posedge clock) disable iff (!reset_n)
    csr_illegal);

endmodule : supervisor_timer_compare

// File: hdl/sup_timer_defines.svh
// CSR numbers, field positions and reset values of the supervisor timer compare unit
`ifndef SUP_TIMER_DEFINES_SVH
`define SUP_TIMER_DEFINES_SVH

// ----------------------------------------------------------------------------
// CSR numbers
// ----------------------------------------------------------------------------
`define CSR_SUP_CMP        12'h14D
`define CSR_SUP_CMP_HIGH   12'h15D
`define CSR_GUEST_CMP      12'h24D
`define CSR_GUEST_CMP_HIGH 12'h25D

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ENVCFG_COMPARE_FEATURE_ENABLE_BIT    63
`define ENVCFGH_COMPARE_FEATURE_ENABLE_BIT   31

// ----------------------------------------------------------------------------
// Reset values and channel layout
// ----------------------------------------------------------------------------
`define CMP_RESET          64'hFFFF_FFFF_FFFF_FFFF
`define COMPARE_FEATURE_ENABLE_RESET         1'h0
`define CMP_CHANNELS       2
`define CMP_CH_SUP         0
`define CMP_CH_GUEST       1

`endif

// File: hdl/sup_timer_pkg.sv
// Types shared by the supervisor timer compare unit
package sup_timer_pkg;

  // --------------------------------------------------------------------------
  // Privilege of the requesting access
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    priv_user,
    priv_supervisor,
    priv_machine
  } priv_mode_t;

  typedef logic [63:0] word64_t;

endpackage : sup_timer_pkg

// File: hdl/timer_ge_compare.sv
// Registered unsigned at-or-past comparator for one timer channel
`timescale 1ns/1ps

module timer_ge_compare
  import sup_timer_pkg::*;
(
  // Clock and reset
  input  logic    clock,
  input  logic    reset_n,
  input  logic    clock_en,
  // Operands
  input  word64_t count_value,
  input  word64_t compare_value,
  // Result
  output logic    at_or_past
);

  // --------------------------------------------------------------------------
  // Compare
  // --------------------------------------------------------------------------
  // One register stage keeps the 64-bit carry chain off the CSR path
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      at_or_past <= 1'h0;
    end else if (clock_en) begin
      at_or_past <= (count_value >= compare_value);
    end
  end

endmodule : timer_ge_compare

// File: sim/time_source.sv
// Platform time source model driving the shared time value
`timescale 1ns/1ps

module time_source
  import sup_timer_pkg::*;
(
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    reset_n,
  // Control
  input  wire logic    run,
  input  wire logic    load,
  input  wire word64_t load_value,
  // Time
  output word64_t      time_value
);
  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // Loads take load_value as given, so time can step back; run only counts up
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      time_value <= 64'h0;
    end else if (load) begin
      time_value <= load_value;
    end else if (run) begin
      time_value <= time_value + 64'h1;
    end
  end
endmodule : time_source

// File: sim/tb_top.sv
// Self-checking testbench of the supervisor timer compare unit
`timescale 1ns/1ps
`include "sup_timer_defines.svh"

module tb_top
  import sup_timer_pkg::*;
;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic clock, reset_n, clock_en, xlen32, hart_virt, csr_req, csr_write, csr_virt;
  logic [11:0] csr_addr;
  priv_mode_t  csr_priv;
  logic csr_hit, csr_ack, csr_illegal, csr_virtual_fault, mcounteren_tm, hcounteren_tm;
  logic menvcfg_we, menvcfgh_we, henvcfg_we, henvcfgh_we, menvcfg_compare_feature_enable, henvcfg_compare_feature_enable;
  logic mip_sup_timer_pending_we, mip_sup_timer_pending_wdata, hvip_guest_timer_pending, mip_sup_timer_pending, sip_sup_timer_pending, hip_guest_timer_pending;
  logic sup_timer_int_enable, sup_int_allowed, guest_timer_int_enable, guest_int_allowed;
  logic sup_timer_irq, guest_timer_irq, t_run, t_load;
  word64_t csr_wdata, csr_rdata, env_wdata, time_value, time_delta, load_value, rd;
  int n_mismatch, compares;

  supervisor_timer_compare uut (.clock, .reset_n, .clock_en, .xlen32, .hart_virt, .csr_req,
    .csr_write, .csr_addr, .csr_wdata, .csr_priv, .csr_virt, .csr_hit, .csr_ack, .csr_illegal,
    .csr_virtual_fault, .csr_rdata, .mcounteren_tm, .hcounteren_tm, .env_wdata, .menvcfg_we,
    .menvcfgh_we, .henvcfg_we, .henvcfgh_we, .menvcfg_compare_feature_enable, .henvcfg_compare_feature_enable, .mip_sup_timer_pending_we,
    .mip_sup_timer_pending_wdata, .hvip_guest_timer_pending, .mip_sup_timer_pending, .sip_sup_timer_pending, .hip_guest_timer_pending, .sup_timer_int_enable,
    .sup_int_allowed, .guest_timer_int_enable, .guest_int_allowed, .sup_timer_irq,
    .guest_timer_irq, .time_value, .time_delta);
  time_source tsrc (.clock, .reset_n, .run(t_run), .load(t_load), .load_value, .time_value);

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input word64_t got, input word64_t exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  // Request driven after one edge, answer read just after the next
  task automatic acc(input logic w, input logic [11:0] a, input word64_t d, input priv_mode_t p,
                     input logic v, input logic e_il, input logic e_vf);
    @(posedge clock); #1;
    csr_req = 1'h1; csr_write = w; csr_addr = a; csr_wdata = d; csr_priv = p; csr_virt = v;
    @(posedge clock); #1;
    csr_req = 1'h0;
    rd = csr_rdata;
    chk_bit(csr_ack, 1'h1);
    chk_bit(csr_illegal, e_il);
    chk_bit(csr_virtual_fault, e_vf);
  endtask : acc

  task automatic env(input logic [1:0] sel, input word64_t d);
    @(posedge clock); #1;
    env_wdata = d; menvcfg_we = (sel == 2'h0); henvcfg_we = (sel == 2'h1);
    henvcfgh_we = (sel == 2'h2); menvcfgh_we = (sel == 2'h3);
    @(posedge clock); #1;
    menvcfg_we = 1'h0; henvcfg_we = 1'h0; henvcfgh_we = 1'h0; menvcfgh_we = 1'h0;
  endtask : env

  task automatic mipw(input logic b);
    @(posedge clock); #1; mip_sup_timer_pending_we = 1'h1; mip_sup_timer_pending_wdata = b;
    @(posedge clock); #1; mip_sup_timer_pending_we = 1'h0;
  endtask : mipw

  // Compare register has already landed in acc; two edges cover the one comparator stage
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic set_time(input word64_t t);
    @(posedge clock); #1; t_load = 1'h1; load_value = t;
    @(posedge clock); #1; t_load = 1'h0;
  endtask : set_time

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // --------------------------------------------------------------------------
  // Clock, watchdog, tests
  // --------------------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  // About 105 cycles of tests; a hang is cut well past that
  initial begin
    #500000;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    n_mismatch = 0; compares = 0; reset_n = 1'h0; clock_en = 1'h1; xlen32 = 1'h0;
    hart_virt = 1'h0; csr_req = 1'h0; csr_write = 1'h0; csr_addr = 12'h0; csr_wdata = 64'h0;
    csr_priv = priv_machine; csr_virt = 1'h0; mcounteren_tm = 1'h1; hcounteren_tm = 1'h1;
    env_wdata = 64'h0; menvcfg_we = 1'h0; menvcfgh_we = 1'h0; henvcfg_we = 1'h0;
    henvcfgh_we = 1'h0; mip_sup_timer_pending_we = 1'h0; mip_sup_timer_pending_wdata = 1'h0; hvip_guest_timer_pending = 1'h0;
    sup_timer_int_enable = 1'h0; sup_int_allowed = 1'h0; guest_timer_int_enable = 1'h0;
    guest_int_allowed = 1'h0; time_delta = 64'h0; load_value = 64'h0; t_run = 1'h0;
    t_load = 1'h0;
    repeat (6) @(posedge clock);
    #1 reset_n = 1'h1;
    chk_bit(menvcfg_compare_feature_enable, 1'h0);
    chk_bit(mip_sup_timer_pending, 1'h0);
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, `CMP_RESET);
    acc(1'h1, `CSR_SUP_CMP, 64'h5, priv_supervisor, 1'h0, 1'h1, 1'h0);
    chk_word(rd, 64'h0);
    mipw(1'h1);
    chk_bit(mip_sup_timer_pending, 1'h1);
    chk_bit(sip_sup_timer_pending, 1'h1);
    mipw(1'h0);
    chk_bit(mip_sup_timer_pending, 1'h0);
    set_time(64'h0000_0001_0000_0000);
    env(2'h0, 64'h8000_0000_0000_0000);
    chk_bit(menvcfg_compare_feature_enable, 1'h1);
    env(2'h2, 64'h0000_0000_8000_0000);
    chk_bit(henvcfg_compare_feature_enable, 1'h1);
    mcounteren_tm = 1'h0;
    acc(1'h1, `CSR_SUP_CMP, 64'h5, priv_supervisor, 1'h0, 1'h1, 1'h0);
    acc(1'h1, `CSR_SUP_CMP, 64'h5, priv_supervisor, 1'h1, 1'h1, 1'h0);
    mcounteren_tm = 1'h1;
    acc(1'h1, `CSR_SUP_CMP, 64'h0000_0001_0000_0000, priv_supervisor, 1'h0, 1'h0, 1'h0);
    settle();
    chk_bit(mip_sup_timer_pending, 1'h1);
    mipw(1'h0);
    chk_bit(mip_sup_timer_pending, 1'h1);
    chk_bit(sip_sup_timer_pending, 1'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock); #1;
      {sup_timer_int_enable, sup_int_allowed} = 2'(i);
      #1 chk_bit(sup_timer_irq, i == 3);
    end
    acc(1'h1, `CSR_SUP_CMP, 64'h0000_0001_0000_0001, priv_supervisor, 1'h0, 1'h0, 1'h0);
    settle();
    chk_bit(mip_sup_timer_pending, 1'h0);
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, 64'h0000_0001_0000_0001);
    t_run = 1'h1;
    repeat (4) @(posedge clock);
    #1 chk_bit(mip_sup_timer_pending, 1'h1);
    t_run = 1'h0;
    // Offset wraps the guest sum past 2^64 down to 0x10
    set_time(64'h0000_0002_0000_0000);
    time_delta = 64'hFFFF_FFFE_0000_0010;
    acc(1'h1, `CSR_SUP_CMP, 64'h10, priv_supervisor, 1'h1, 1'h0, 1'h0);
    settle();
    chk_bit(hip_guest_timer_pending, 1'h1);
    acc(1'h0, `CSR_GUEST_CMP, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, 64'h10);
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, 64'h0000_0001_0000_0001);
    acc(1'h1, `CSR_SUP_CMP, 64'h11, priv_supervisor, 1'h1, 1'h0, 1'h0);
    settle();
    chk_bit(hip_guest_timer_pending, 1'h0);
    hvip_guest_timer_pending = 1'h1;
    #1 chk_bit(hip_guest_timer_pending, 1'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock); #1;
      {hart_virt, guest_timer_int_enable, guest_int_allowed} = 3'(i);
      #1 chk_bit(guest_timer_irq, i == 7);
    end
    @(posedge clock); #1;
    hart_virt = 1'h0; hvip_guest_timer_pending = 1'h0;
    acc(1'h1, `CSR_SUP_CMP, 64'h10, priv_supervisor, 1'h1, 1'h0, 1'h0);
    settle();
    chk_bit(hip_guest_timer_pending, 1'h1);
    hcounteren_tm = 1'h0;
    acc(1'h1, `CSR_SUP_CMP, 64'h5, priv_supervisor, 1'h1, 1'h0, 1'h1);
    hcounteren_tm = 1'h1;
    acc(1'h1, `CSR_GUEST_CMP, 64'h5, priv_supervisor, 1'h1, 1'h0, 1'h1);
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_user, 1'h0, 1'h1, 1'h0);
    // Guest user mode never reaches the compare, even with every gate open
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_user, 1'h1, 1'h0, 1'h1);
    env(2'h1, 64'h0);
    chk_bit(henvcfg_compare_feature_enable, 1'h0);
    chk_bit(hip_guest_timer_pending, 1'h0);
    acc(1'h1, `CSR_SUP_CMP, 64'h5, priv_supervisor, 1'h1, 1'h0, 1'h1);
    xlen32 = 1'h1;
    acc(1'h1, `CSR_SUP_CMP_HIGH, 64'hAAAA_5555, priv_machine, 1'h0, 1'h0, 1'h0);
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, 64'h1);
    acc(1'h1, `CSR_GUEST_CMP_HIGH, 64'h1234_ABCD, priv_machine, 1'h0, 1'h0, 1'h0);
    acc(1'h0, `CSR_GUEST_CMP_HIGH, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, 64'h1234_ABCD);
    xlen32 = 1'h0;
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, 64'hAAAA_5555_0000_0001);
    acc(1'h0, `CSR_GUEST_CMP, 64'h0, priv_machine, 1'h0, 1'h0, 1'h0);
    chk_word(rd, 64'h1234_ABCD_0000_0010);
    @(posedge clock); #1;
    csr_req = 1'h1; csr_addr = `CSR_SUP_CMP_HIGH; csr_write = 1'h0;
    #1 chk_bit(csr_hit, 1'h0);
    @(posedge clock); #1;
    csr_req = 1'h0;
    chk_bit(csr_ack, 1'h0);
    env(2'h2, 64'h0000_0000_8000_0000);
    env(2'h0, 64'h0);
    chk_bit(henvcfg_compare_feature_enable, 1'h0);
    chk_bit(mip_sup_timer_pending, 1'h0);
    acc(1'h0, `CSR_SUP_CMP, 64'h0, priv_supervisor, 1'h0, 1'h1, 1'h0);
    // High-half strobe re-enables; the masked hypervisor bit comes back
    env(2'h3, 64'h0000_0000_8000_0000);
    chk_bit(menvcfg_compare_feature_enable, 1'h1);
    chk_bit(henvcfg_compare_feature_enable, 1'h1);
    conclude();
  end
endmodule : tb_top
